// [irq_pkg.sv]
// Constants, types and register map of the interrupt flag and edge block
//
// Behaviour
// - Vector table select bit steers dispatch table
// - Hold status bit is read-only, mirrors core
// - Polarity bit picks falling or rising edge
// - Control bits 13 to 5 read zero
// - Flags latch requests, software reads and writes
// - Flags zero upper byte layout
// - Flags zero lower byte layout
// - Flags one upper byte layout
// - Flags one lower byte layout
// - Flags two upper byte layout
// - Flags two lower byte layout
// - Unused flag positions read zero
`default_nettype none
package irq_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  CTRL2_OFFSET   = 8'h00;
  localparam logic [7:0]  FLAGS0_OFFSET  = 8'h04;
  localparam logic [7:0]  FLAGS1_OFFSET  = 8'h08;
  localparam logic [7:0]  FLAGS2_OFFSET  = 8'h0c;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h10;
  localparam logic [7:0]  CLEAR_OFFSET   = 8'h14;
  localparam logic [7:0]  ENABLE_OFFSET  = 8'h18;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int          EXT_N          = 5;
  localparam int          VTS_BIT        = 15;
  localparam int          HOLD_BIT       = 14;
  localparam int          POL_LSB        = 0;
  localparam int          EXT0_FLAG_BIT  = 0;
  localparam int          EXT1_FLAG_BIT  = 4;
  localparam int          EXT2_FLAG_BIT  = 13;
  localparam logic [15:0] FLAGS0_MASK    = 16'h7fff;
  localparam logic [15:0] FLAGS1_MASK    = 16'hfffb;
  localparam logic [15:0] FLAGS2_MASK    = 16'hdfff;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0]      FLAGS_RESET = 16'h0000;
  localparam logic [EXT_N-1:0] EXT_RESET   = 5'h00;

  // Request or pending flags of the three flag registers
  typedef struct packed {
    logic [15:0] flags2;
    logic [15:0] flags1;
    logic [15:0] flags0;
  } flag_set_t;

endpackage
`default_nettype wire

// [ext_edge_detect.sv]
// Per-pin edge detector with selectable polarity
`timescale 1ns/100ps
`default_nettype none
module ext_edge_detect
(
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // Pins and polarity
  input  wire logic [irq_pkg::EXT_N-1:0] pin,
  input  wire logic [irq_pkg::EXT_N-1:0] polarity,
  // Detected edges
  output logic      [irq_pkg::EXT_N-1:0] edge_pulse
);
  import irq_pkg::*;

  // ****************************************
  // Edge detection per pin
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < EXT_N; i++)
    begin : g_pin
      logic prev_r;
      logic primed_r;

      // Previous level, primed once a real sample exists
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          prev_r   <= 1'b0;
          primed_r <= 1'b0;
        end
        else
        begin
          prev_r   <= pin[i];
          primed_r <= 1'b1;
        end
      end

      // Falling edge when polarity is one, rising otherwise
      assign edge_pulse[i] = primed_r &&
                             (polarity[i] ? (prev_r && !pin[i])
                                          : (!prev_r && pin[i]));

      neg_edge_a: assert property (@(posedge core_clk) disable iff (rst)
        primed_r && polarity[i] && $fell(pin[i]) |-> edge_pulse[i])
        else $error("falling edge missed");
      pos_edge_a: assert property (@(posedge core_clk) disable iff (rst)
        edge_pulse[i] && !polarity[i] |-> pin[i] && !$past(pin[i]))
        else $error("rising edge wrong");
    end
  endgenerate

endmodule
`default_nettype wire

// [irq_flag_ctrl.sv]
// Interrupt control two, flag registers and edge interrupts over AXI4-Lite
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module irq_flag_ctrl
(
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // AXI4-Lite write address
  input  wire logic [irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]                 s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0]                s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Interrupt sources
  input  wire logic [irq_pkg::EXT_N-1:0]  ext_irq_pin,
  input  wire irq_pkg::flag_set_t         periph_req,
  input  wire logic                       interrupt_hold_active,
  // Core side
  output logic                            vector_table_select,
  output irq_pkg::flag_set_t              pending_flags,
  output logic                            irq
);
  import irq_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic                aw_hold_r;
  logic [ADDR_W-1:0]   aw_addr_r;
  logic                w_hold_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                rvalid_r;
  logic [1:0]          rresp_r;
  logic [31:0]         rdata_r;
  logic                do_write;
  logic                ar_take;
  logic [15:0]         byte_mask;
  logic                vts_r;
  logic [EXT_N-1:0]    pol_r;
  logic [15:0]         flags0_r;
  logic [15:0]         flags1_r;
  logic [15:0]         flags2_r;
  logic [15:0]         flags0_nxt;
  logic [15:0]         flags1_nxt;
  logic [15:0]         flags2_nxt;
  logic [15:0]         ext_set0;
  logic [15:0]         ext_set1;
  logic [EXT_N-1:0]    int_status_r;
  logic [EXT_N-1:0]    int_enable_r;
  logic [EXT_N-1:0]    ext_edge;
  logic [15:0]         ctrl2_view;
  logic                wr_ctrl2;
  logic                wr_flags0;
  logic                wr_flags1;
  logic                wr_flags2;
  logic                wr_clear;
  logic                wr_enable;

  // ****************************************
  // Edge detection on the external pins
  // ****************************************
  ext_edge_detect u_edge (
    .core_clk   (core_clk),
    .rst        (rst),
    .pin        (ext_irq_pin),
    .polarity   (pol_r),
    .edge_pulse (ext_edge)
  );

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign do_write      = aw_hold_r && w_hold_r && !bvalid_r;
  assign byte_mask     = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // Address and data captured in either order
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (do_write)
        aw_hold_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (do_write)
        w_hold_r <= 1'b0;
    end
  end

  // Write response once both halves are in
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (aw_addr_r == STATUS_OFFSET || aw_addr_r > ENABLE_OFFSET ||
                   aw_addr_r[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // Register write decode
  assign wr_ctrl2  = do_write && aw_addr_r == CTRL2_OFFSET;
  assign wr_flags0 = do_write && aw_addr_r == FLAGS0_OFFSET;
  assign wr_flags1 = do_write && aw_addr_r == FLAGS1_OFFSET;
  assign wr_flags2 = do_write && aw_addr_r == FLAGS2_OFFSET;
  assign wr_clear  = do_write && aw_addr_r == CLEAR_OFFSET && w_strb_r[0];
  assign wr_enable = do_write && aw_addr_r == ENABLE_OFFSET && w_strb_r[0];

  // ****************************************
  // Interrupt control two
  // ****************************************
  // Only the table select and polarity bits are stored
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      vts_r <= 1'b0;
      pol_r <= EXT_RESET;
    end
    else if (wr_ctrl2)
    begin
      if (w_strb_r[1])
        vts_r <= w_data_r[VTS_BIT];
      if (w_strb_r[0])
        pol_r <= w_data_r[POL_LSB +: EXT_N];
    end
  end

  assign vector_table_select = vts_r;

  // Read view: hold bit from the core, gap reads zero
  always_comb
  begin
    ctrl2_view                   = 16'h0000;
    ctrl2_view[VTS_BIT]          = vts_r;
    ctrl2_view[HOLD_BIT]         = interrupt_hold_active;
    ctrl2_view[POL_LSB +: EXT_N] = pol_r;
  end

  // ****************************************
  // Interrupt flag registers
  // ****************************************
  // External pin flags join the peripheral requests
  always_comb
  begin
    ext_set0                = 16'h0000;
    ext_set1                = 16'h0000;
    ext_set0[EXT0_FLAG_BIT] = ext_edge[0];
    ext_set1[EXT1_FLAG_BIT] = ext_edge[1];
    ext_set1[EXT2_FLAG_BIT] = ext_edge[2];
  end

  // Software write first, then requests set on top
  always_comb
  begin
    flags0_nxt = wr_flags0 ? ((flags0_r & ~byte_mask) | (w_data_r[15:0] & byte_mask))
                           : flags0_r;
    flags1_nxt = wr_flags1 ? ((flags1_r & ~byte_mask) | (w_data_r[15:0] & byte_mask))
                           : flags1_r;
    flags2_nxt = wr_flags2 ? ((flags2_r & ~byte_mask) | (w_data_r[15:0] & byte_mask))
                           : flags2_r;
    flags0_nxt = (flags0_nxt | periph_req.flags0 | ext_set0) & FLAGS0_MASK;
    flags1_nxt = (flags1_nxt | periph_req.flags1 | ext_set1) & FLAGS1_MASK;
    flags2_nxt = (flags2_nxt | periph_req.flags2) & FLAGS2_MASK;
  end

  // Flag storage, unused positions forced low
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      flags0_r <= FLAGS_RESET;
      flags1_r <= FLAGS_RESET;
      flags2_r <= FLAGS_RESET;
    end
    else
    begin
      flags0_r <= flags0_nxt;
      flags1_r <= flags1_nxt;
      flags2_r <= flags2_nxt;
    end
  end

  assign pending_flags = '{flags2: flags2_r, flags1: flags1_r, flags0: flags0_r};

  // ****************************************
  // Edge interrupt status, clear and enable
  // ****************************************
  // Sticky status, a new edge wins over a clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      int_status_r <= EXT_RESET;
    else if (wr_clear)
      int_status_r <= (int_status_r & ~w_data_r[EXT_N-1:0]) | ext_edge;
    else
      int_status_r <= int_status_r | ext_edge;
  end

  // Enable mask
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      int_enable_r <= EXT_RESET;
    else if (wr_enable)
      int_enable_r <= w_data_r[EXT_N-1:0];
  end

  assign irq = |(int_status_r & int_enable_r);

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = !rvalid_r;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  // Read data registered one cycle after the address
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
      unique case (s_axi_araddr)
        CTRL2_OFFSET:  rdata_r[15:0]      <= ctrl2_view;
        FLAGS0_OFFSET: rdata_r[15:0]      <= flags0_r;
        FLAGS1_OFFSET: rdata_r[15:0]      <= flags1_r;
        FLAGS2_OFFSET: rdata_r[15:0]      <= flags2_r;
        STATUS_OFFSET: rdata_r[EXT_N-1:0] <= int_status_r;
        CLEAR_OFFSET:  rdata_r            <= '0;
        ENABLE_OFFSET: rdata_r[EXT_N-1:0] <= int_enable_r;
        default:       rresp_r            <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  table_select_a: assert property (
    wr_ctrl2 && w_strb_r[1] |=> vector_table_select == $past(w_data_r[VTS_BIT]))
    else $error("table select not updated");

  hold_bit_a: assert property (
    ar_take && s_axi_araddr == CTRL2_OFFSET
    |=> s_axi_rdata[HOLD_BIT] == $past(interrupt_hold_active))
    else $error("hold bit not mirrored");

  ctrl_gap_a: assert property (
    ar_take && s_axi_araddr == CTRL2_OFFSET |=> s_axi_rdata[13:5] == 9'h000)
    else $error("control gap not zero");

  req_set_a: assert property (
    periph_req.flags1[3] |=> pending_flags.flags1[3] ##1 pending_flags.flags1[3]
    || $past(wr_flags1))
    else $error("request not latched");

  flag_clear_a: assert property (
    wr_flags2 && w_strb_r[1:0] == 2'h3 && w_data_r[15:0] == 16'h0000
    |=> (pending_flags.flags2 & ~$past(periph_req.flags2)) == 16'h0000)
    else $error("flag clear failed");

  unused_zero_a: assert property (
    !flags0_r[15] && !flags1_r[2] && !flags2_r[13])
    else $error("unused flag set");

  ext_flag_a: assert property (
    ext_edge[0] |=> flags0_r[EXT0_FLAG_BIT] [*2] or
    (flags0_r[EXT0_FLAG_BIT] ##1 $past(wr_flags0)))
    else $error("pin flag not set");

  flag_hold_a: assert property (
    flags1_r[EXT2_FLAG_BIT] && !(wr_flags1 && w_strb_r[1]) |=> flags1_r[EXT2_FLAG_BIT])
    else $error("pin flag dropped");

  irq_level_a: assert property (
    ext_edge[1] && int_enable_r[1] && !wr_enable |=> irq)
    else $error("interrupt not raised");

  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("response dropped");

  cov_ctrl_write_c: cover property (wr_ctrl2 && w_data_r[VTS_BIT]);
  cov_ext_edge_c:   cover property (ext_edge[0] ##1 flags0_r[EXT0_FLAG_BIT]);
  cov_irq_c:        cover property ($rose(irq));
  cov_read_c:       cover property (ar_take ##1 s_axi_rvalid && s_axi_rready);

endmodule
`default_nettype wire

// [irq_src_model.sv]
// Behavioural model of the peripheral and core sources facing the flag block
`timescale 1ns/100ps
`default_nettype none
module irq_src_model
(
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // Bench commands
  input  wire logic                      fire,
  input  wire irq_pkg::flag_set_t        fire_mask,
  input  wire logic [irq_pkg::EXT_N-1:0] pin_lvl,
  input  wire logic                      hold_lvl,
  // Source outputs
  output irq_pkg::flag_set_t             periph_req,
  output logic      [irq_pkg::EXT_N-1:0] ext_irq_pin,
  output logic                           interrupt_hold_active
);
  import irq_pkg::*;

  // Requests last one cycle, pins and hold follow the bench a cycle late
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      periph_req            <= '0;
      ext_irq_pin           <= '0;
      interrupt_hold_active <= 1'b0;
    end
    else
    begin
      periph_req            <= fire ? fire_mask : '0;
      ext_irq_pin           <= pin_lvl;
      interrupt_hold_active <= hold_lvl;
    end
  end
endmodule
`default_nettype wire

// [test_interrupt_flag_and_edge_control.sv]
// Self-checking bench of the interrupt flag and edge block
`timescale 1ns/100ps
`default_nettype none
module test_interrupt_flag_and_edge_control;
  import irq_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr, a;
  logic [2:0]        s_axi_awprot, s_axi_arprot;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, interrupt_hold_active;
  logic [EXT_N-1:0]  ext_irq_pin, pin_lvl;
  flag_set_t         periph_req, pending_flags, fire_mask;
  logic              vector_table_select, irq, fire, hold_lvl;
  logic [15:0]       d;
  logic [15:0]       msk [3];
  logic [47:0]       e;
  int                n_fail = 0;
  int                compares = 0;

  // Clock at 20 MHz
  always #25 core_clk = ~core_clk;

  // Block under test and its sources
  irq_flag_ctrl dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin,
    .periph_req, .interrupt_hold_active, .vector_table_select, .pending_flags, .irq);
  irq_src_model src (.core_clk, .rst, .fire, .fire_mask, .pin_lvl, .hold_lvl, .periph_req,
    .ext_irq_pin, .interrupt_hold_active);

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [47:0] g, input logic [47:0] x, input string m);
    compares++;
    if (g !== x)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, g, x);
    end
  endtask

  task automatic tmo();
    n_fail++;
    $display("[FAIL] %0t bus wait ran out", $time);
    final_report();
  endtask

  // Expected control two read value
  function automatic logic [15:0] ctrl_exp(input logic [15:0] v, input logic h);
    return {v[15], h, 9'h000, v[4:0]};
  endfunction

  task automatic wr(input logic [7:0] ad, input logic [15:0] v, input logic [1:0] er);
    int   n;
    logic ta, tw, tb;
    logic [1:0] r;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      if (++n > 50) tmo();
    end
    while (!tb);
    chk({46'h0, r}, {46'h0, er}, "bresp");
  endtask

  task automatic rd(input logic [7:0] ad, input logic [15:0] x, input logic [1:0] er);
    int   n;
    logic ta, tb;
    logic [31:0] v;
    logic [1:0]  r;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      v  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tb) s_axi_rready <= 1'b0;
      if (++n > 50) tmo();
    end
    while (!tb);
    chk({16'h0, v}, {32'h0, x}, "rdata");
    chk({46'h0, r}, {46'h0, er}, "rresp");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h3;
    {fire, fire_mask, pin_lvl, hold_lvl} = '0;
    msk = '{FLAGS0_MASK, FLAGS1_MASK, FLAGS2_MASK};
    void'($urandom(34359));
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk(vector_table_select, 1'b0, "table reset");
    rd(CTRL2_OFFSET, 16'h0000, RESP_OKAY);
    for (int k = 0; k < 3; k++)
      rd(FLAGS0_OFFSET + 8'(4 * k), FLAGS_RESET, RESP_OKAY);
    // Control two with hold low and high
    wr(CTRL2_OFFSET, 16'hffff, RESP_OKAY);
    rd(CTRL2_OFFSET, 16'h801f, RESP_OKAY);
    chk(vector_table_select, 1'b1, "table alt");
    hold_lvl <= 1'b1;
    rd(CTRL2_OFFSET, 16'hc01f, RESP_OKAY);
    wr(CTRL2_OFFSET, 16'h0000, RESP_OKAY);
    rd(CTRL2_OFFSET, 16'h4000, RESP_OKAY);
    chk(vector_table_select, 1'b0, "table std");
    hold_lvl <= 1'b0;
    repeat (6)
    begin
      d = 16'($urandom);
      wr(CTRL2_OFFSET, d, RESP_OKAY);
      rd(CTRL2_OFFSET, ctrl_exp(d, 1'b0), RESP_OKAY);
      chk(vector_table_select, d[15], "table rnd");
    end
    // Software access to the flag registers
    for (int k = 0; k < 3; k++)
    begin
      d = 16'($urandom);
      wr(FLAGS0_OFFSET + 8'(4 * k), d, RESP_OKAY);
      rd(FLAGS0_OFFSET + 8'(4 * k), d & msk[k], RESP_OKAY);
      wr(FLAGS0_OFFSET + 8'(4 * k), 16'h0000, RESP_OKAY);
      rd(FLAGS0_OFFSET + 8'(4 * k), 16'h0000, RESP_OKAY);
    end
    // Lane 0 strobe alone leaves the upper byte untouched
    s_axi_wstrb <= 4'h1;
    wr(FLAGS2_OFFSET, 16'hffff, RESP_OKAY);
    s_axi_wstrb <= 4'h3;
    rd(FLAGS2_OFFSET, 16'h00ff, RESP_OKAY);
    wr(FLAGS2_OFFSET, 16'h0000, RESP_OKAY);
    rd(FLAGS2_OFFSET, 16'h0000, RESP_OKAY);
    // One request pulse per source position
    for (int b = 0; b < 48; b++)
    begin
      e = (48'h1 << b) & {FLAGS2_MASK, FLAGS1_MASK, FLAGS0_MASK};
      a = FLAGS0_OFFSET + 8'(4 * (b / 16));
      @(posedge core_clk);
      fire_mask <= 48'h1 << b;
      fire      <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
      repeat (3) @(negedge core_clk);
      chk(pending_flags, e, "pending");
      rd(a, 16'(e >> (16 * (b / 16))), RESP_OKAY);
      wr(a, 16'h0000, RESP_OKAY);
    end
    // Edge polarity on every pin, right and wrong edge
    wr(ENABLE_OFFSET, 16'h001f, RESP_OKAY);
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < EXT_N; i++)
      begin
        wr(CTRL2_OFFSET, (p != 0) ? 16'h001f : 16'h0000, RESP_OKAY);
        pin_lvl <= (p != 0) ? 5'h1f : 5'h00;
        repeat (4) @(posedge core_clk);
        wr(CLEAR_OFFSET, 16'h001f, RESP_OKAY);
        wr(FLAGS0_OFFSET, 16'h0000, RESP_OKAY);
        wr(FLAGS1_OFFSET, 16'h0000, RESP_OKAY);
        pin_lvl[i] <= (p == 0);
        repeat (6) @(negedge core_clk);
        chk(irq, 1'b1, "irq raised");
        rd(STATUS_OFFSET, 16'h1 << i, RESP_OKAY);
        rd(FLAGS0_OFFSET, (i == 0) ? 16'h0001 : 16'h0000, RESP_OKAY);
        d = (i == 1) ? 16'h0010 : (i == 2) ? 16'h2000 : 16'h0000;
        rd(FLAGS1_OFFSET, d, RESP_OKAY);
        wr(CLEAR_OFFSET, 16'h1 << i, RESP_OKAY);
        pin_lvl[i] <= (p != 0);
        repeat (6) @(negedge core_clk);
        chk(irq, 1'b0, "irq cleared");
        rd(STATUS_OFFSET, 16'h0000, RESP_OKAY);
      end
    // Masked edge, then unmasked
    wr(ENABLE_OFFSET, 16'h0000, RESP_OKAY);
    pin_lvl[0] <= 1'b0;
    repeat (6) @(negedge core_clk);
    chk(irq, 1'b0, "irq masked");
    rd(STATUS_OFFSET, 16'h0001, RESP_OKAY);
    wr(ENABLE_OFFSET, 16'h0001, RESP_OKAY);
    @(negedge core_clk);
    chk(irq, 1'b1, "irq unmasked");
    // Refused and odd accesses
    rd(8'h1c, 16'h0000, RESP_SLVERR);
    rd(8'h02, 16'h0000, RESP_SLVERR);
    wr(STATUS_OFFSET, 16'hffff, RESP_SLVERR);
    rd(CLEAR_OFFSET, 16'h0000, RESP_OKAY);
    // Reset in mid-run with table select and flags set
    wr(CTRL2_OFFSET, 16'h8000, RESP_OKAY);
    wr(FLAGS1_OFFSET, 16'hffff, RESP_OKAY);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk(pending_flags, 48'h0, "flags after reset");
    chk(vector_table_select, 1'b0, "table after reset");
    chk(irq, 1'b0, "irq after reset");
    final_report();
  end
endmodule
`default_nettype wire
